// ---- rtl/wfd_pkg.sv ----
// shared constants, types and helpers of the wake frame detector
package wfd_pkg;
  // register bus
  localparam int          AXI_AW          = 4;
  localparam logic [3:0]  OFS_CTRL        = 4'h0;
  localparam logic [3:0]  OFS_TABLE       = 4'h4;
  localparam logic [3:0]  OFS_STA_LO      = 4'h8;
  localparam logic [3:0]  OFS_STA_HI      = 4'hC;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // wake_control_status fields
  localparam int          BIT_REMOTE_EN   = 0;
  localparam int          BIT_PATTERN_EN  = 1;
  localparam int          BIT_NOTIFY_EVT  = 2;
  localparam int          BIT_PTR_RESTART = 3;
  localparam int          BIT_REMOTE_SEEN = 4;
  localparam int          BIT_PATTERN_SEEN = 5;
  localparam int          POS_PTR         = 8;
  localparam logic [47:0] STATION_RST     = 48'h0000_0000_0000;
  // wake_filter_table layout
  localparam int          NUM_FILTERS     = 4;
  localparam int          TABLE_WORDS     = 8;
  localparam int          IDX_COMMAND     = 4;
  localparam int          IDX_OFFSET      = 5;
  localparam int          IDX_CRC_LO      = 6;
  localparam int          IDX_CRC_HI      = 7;
  localparam int          CMD_ENABLE      = 0;
  localparam int          CMD_MULTICAST   = 3;
  localparam int          MASK_BITS       = 31;
  // frame layout and remote-wake packet shape
  localparam logic [10:0] ADDR_FIELDS_END = 11'd12;
  localparam logic [10:0] DEST_LEN        = 11'd6;
  localparam logic [2:0]  SYNC_LEN        = 3'd6;
  localparam logic [2:0]  ADDR_LAST_BYTE  = 3'd5;
  localparam logic [3:0]  ADDR_LAST_REP   = 4'd15;
  localparam logic [7:0]  SYNC_BYTE       = 8'hFF;
  // crc-16 engine
  localparam logic [15:0] CRC_POLY        = 16'h8005;
  localparam logic [15:0] CRC_INIT        = 16'hFFFF;

  typedef enum logic [0:0] {
    SCAN_SYNC = 1'b0,
    SCAN_ADDR = 1'b1
  } wfd_scan_type;

  // byte-lane merge of a bus write into an old word
  function automatic logic [31:0] wfd_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  // one byte through the crc-16, msb first
  function automatic logic [15:0] wfd_crc16(input logic [15:0] c_in,
                                           input logic [7:0]  d);
    logic [15:0] c;
    logic        fb;
    c = c_in;
    for (int k = 7; k >= 0; k--)
    begin
      fb = c[15] ^ d[k];
      c  = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    return c;
  endfunction
endpackage

// ---- rtl/wfd_tbl_if.sv ----
// carrier between the detector and its filter table memory
`timescale 1ns/1ps
interface wfd_tbl_if;
  logic                                 wr_en;
  logic [2:0]                           wr_idx;
  logic [31:0]                          wr_data;
  logic [3:0]                           wr_strb;
  logic [2:0]                           rd_idx;
  logic [31:0]                          rd_data;
  logic [wfd_pkg::TABLE_WORDS-1:0][31:0] table_q;

  modport ctrl (output wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                input  rd_data, table_q);
  modport mem  (input  wr_en, wr_idx, wr_data, wr_strb, rd_idx,
                output rd_data, table_q);
endinterface

// ---- rtl/wfd_table_mem.sv ----
// eight-word wake filter table with registered read data
`timescale 1ns/1ps
module wfd_table_mem
  import wfd_pkg::*;
#(
  parameter int DEPTH = wfd_pkg::TABLE_WORDS
)(
  input  wire logic clk,
  input  wire logic rst,
  wfd_tbl_if.mem    tbl
);
  typedef struct packed {
    logic [DEPTH-1:0][31:0] mem;
    logic [31:0]            rd_data;
    logic [DEPTH-1:0][31:0] table_q;
  } wfd_mem_state_type;

  wfd_mem_state_type s_r;
  wfd_mem_state_type s_nxt;

  // byte-lane write, registered read port and registered table copy
  always_comb
  begin
    s_nxt = s_r;
    if (tbl.wr_en)
      s_nxt.mem[tbl.wr_idx] = wfd_merge(s_r.mem[tbl.wr_idx], tbl.wr_data,
                                        tbl.wr_strb);
    s_nxt.rd_data = s_r.mem[tbl.rd_idx];
    s_nxt.table_q = s_r.mem;
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tbl.rd_data = s_r.rd_data;
  assign tbl.table_q = s_r.table_q;
endmodule

// ---- rtl/wfd_top.sv ----
// wake frame detector: pattern filters, remote-wake scan, axi4-lite regs
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module wfd_top
  import wfd_pkg::*;
(
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic [wfd_pkg::AXI_AW-1:0] AWADDR,
  input  wire logic                       AWVALID,
  output logic                            AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic [3:0]                 WSTRB,
  input  wire logic                       WVALID,
  output logic                            WREADY,
  output logic [1:0]                      BRESP,
  output logic                            BVALID,
  input  wire logic                       BREADY,
  input  wire logic [wfd_pkg::AXI_AW-1:0] ARADDR,
  input  wire logic                       ARVALID,
  output logic                            ARREADY,
  output logic [31:0]                     RDATA,
  output logic [1:0]                      RRESP,
  output logic                            RVALID,
  input  wire logic                       RREADY,
  input  wire logic [7:0]                 RX_DATA,
  input  wire logic                       RX_VALID,
  input  wire logic                       RX_SOF,
  input  wire logic                       RX_EOF,
  input  wire logic                       LIGHT_SLEEP,
  output logic                            RX_PASS,
  output logic                            IRQ_OUT,
  output logic                            POWER_EVENT_OUT
);
  typedef struct packed {
    logic                          awready;
    logic                          wready;
    logic                          aw_full;
    logic                          w_full;
    logic [AXI_AW-1:0]             awaddr;
    logic [31:0]                   wdata;
    logic [3:0]                    wstrb;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic                          remote_wake_scan_enable;
    logic                          pattern_wake_enable;
    logic                          notify_evt;
    logic                          remote_wake_seen_flag;
    logic                          pattern_wake_seen_flag;
    logic [47:0]                   station;
    logic [2:0]                    tbl_ptr;
    logic [10:0]                   pos;
    logic                          own_ok;
    logic                          bc_ok;
    logic                          mc;
    logic [NUM_FILTERS-1:0][15:0]  crc;
    logic                          eof_d;
    wfd_scan_type                  scan;
    logic [2:0]                    ff_cnt;
    logic [2:0]                    byte_idx;
    logic [3:0]                    rep_cnt;
    logic                          rx_pass;
    logic                          irq;
    logic                          pwr_evt;
  } wfd_state_type;

  wfd_state_type s_r;
  wfd_state_type s_nxt;
  wfd_tbl_if     tbl ();

  logic          do_write;
  logic          remote_active;
  logic          pattern_active;
  logic          remote_hit;
  logic          pattern_hit;
  logic [10:0]   cur_pos;
  logic [10:0]   rel;
  logic [7:0]    f_ofs;
  logic [3:0]    f_cmd;
  logic [15:0]   f_crc;
  logic [7:0]    exp_byte;
  logic          dest_ok;

  wfd_table_mem u_mem (
    .clk (CLK),
    .rst (RST),
    .tbl (tbl.mem)
  );

  // write strobe toward the table, pointer walks through the eight words
  assign do_write     = s_r.aw_full && s_r.w_full && !s_r.bvalid;
  assign tbl.wr_en    = do_write && (s_r.awaddr == OFS_TABLE);
  assign tbl.wr_idx   = s_r.tbl_ptr;
  assign tbl.wr_data  = s_r.wdata;
  assign tbl.wr_strb  = s_r.wstrb;
  assign tbl.rd_idx   = s_r.tbl_ptr;

  // scan enables from software bits and light sleep
  assign remote_active  = s_r.remote_wake_scan_enable || LIGHT_SLEEP;
  assign pattern_active = s_r.pattern_wake_enable || LIGHT_SLEEP;

  // next-state logic for bus, registers and receive scanning
  always_comb
  begin
    s_nxt       = s_r;
    remote_hit  = 1'b0;
    pattern_hit = 1'b0;
    rel         = '0;
    f_ofs       = '0;
    f_cmd       = '0;
    f_crc       = '0;
    exp_byte    = '0;
    dest_ok     = 1'b0;
    cur_pos     = RX_SOF ? 11'd0 : s_r.pos;

    // write address and data taken in either order
    if (AWVALID && s_r.awready)
    begin
      s_nxt.aw_full = 1'b1;
      s_nxt.awaddr  = AWADDR;
    end
    if (WVALID && s_r.wready)
    begin
      s_nxt.w_full = 1'b1;
      s_nxt.wdata  = WDATA;
      s_nxt.wstrb  = WSTRB;
    end
    if (do_write)
    begin
      s_nxt.aw_full = 1'b0;
      s_nxt.w_full  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = RESP_OKAY;
      case (s_r.awaddr)
        OFS_CTRL:
        begin
          if (s_r.wstrb[0])
          begin
            s_nxt.remote_wake_scan_enable = s_r.wdata[BIT_REMOTE_EN];
            s_nxt.pattern_wake_enable     = s_r.wdata[BIT_PATTERN_EN];
            s_nxt.notify_evt              = s_r.wdata[BIT_NOTIFY_EVT];
            if (s_r.wdata[BIT_PTR_RESTART])
              s_nxt.tbl_ptr = '0;
            if (s_r.wdata[BIT_REMOTE_SEEN])
              s_nxt.remote_wake_seen_flag = 1'b0;
            if (s_r.wdata[BIT_PATTERN_SEEN])
              s_nxt.pattern_wake_seen_flag = 1'b0;
          end
        end
        OFS_TABLE: s_nxt.tbl_ptr = s_r.tbl_ptr + 3'd1;
        OFS_STA_LO:
          s_nxt.station[31:0] = wfd_merge(s_r.station[31:0], s_r.wdata,
                                          s_r.wstrb);
        OFS_STA_HI:
          s_nxt.station[47:32] = 16'(wfd_merge({16'h0000,
                                  s_r.station[47:32]}, s_r.wdata,
                                  s_r.wstrb));
        default: s_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && BREADY)
      s_nxt.bvalid = 1'b0;
    s_nxt.awready = !s_nxt.aw_full && !s_nxt.bvalid;
    s_nxt.wready  = !s_nxt.w_full && !s_nxt.bvalid;

    // read address taken, data answered one edge later
    if (ARVALID && s_r.arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = RESP_OKAY;
      case (ARADDR)
        OFS_CTRL:
        begin
          s_nxt.rdata = '0;
          s_nxt.rdata[BIT_REMOTE_EN]    = s_r.remote_wake_scan_enable;
          s_nxt.rdata[BIT_PATTERN_EN]   = s_r.pattern_wake_enable;
          s_nxt.rdata[BIT_NOTIFY_EVT]   = s_r.notify_evt;
          s_nxt.rdata[BIT_REMOTE_SEEN]  = s_r.remote_wake_seen_flag;
          s_nxt.rdata[BIT_PATTERN_SEEN] = s_r.pattern_wake_seen_flag;
          s_nxt.rdata[POS_PTR +: 3]     = s_r.tbl_ptr;
        end
        OFS_TABLE:  s_nxt.rdata = tbl.rd_data;
        OFS_STA_LO: s_nxt.rdata = s_r.station[31:0];
        OFS_STA_HI: s_nxt.rdata = {16'h0000, s_r.station[47:32]};
        default:
        begin
          s_nxt.rdata = '0;
          s_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && RREADY)
      s_nxt.rvalid = 1'b0;
    s_nxt.arready = !s_nxt.rvalid && !(ARVALID && s_r.arready);

    // pattern filters judged the cycle after the last byte
    if (s_r.eof_d && pattern_active)
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        f_cmd = tbl.table_q[IDX_COMMAND][8*i +: 4];
        f_crc = tbl.table_q[IDX_CRC_LO + i/2][16*(i%2) +: 16];
        if (f_cmd[CMD_ENABLE]
            && (f_cmd[CMD_MULTICAST] == s_r.mc)
            && (s_r.crc[i] == f_crc))
          pattern_hit = 1'b1;
      end
    s_nxt.eof_d = RX_VALID && RX_EOF;

    if (RX_VALID)
    begin
      s_nxt.pos = (cur_pos == 11'h7FF) ? cur_pos : cur_pos + 11'd1;
      // destination classification over the first six bytes
      if (RX_SOF)
      begin
        s_nxt.own_ok  = 1'b1;
        s_nxt.bc_ok   = 1'b1;
        s_nxt.crc     = {NUM_FILTERS{CRC_INIT}};
        s_nxt.scan    = SCAN_SYNC;
        s_nxt.ff_cnt  = '0;
        s_nxt.rep_cnt = '0;
      end
      if (cur_pos < DEST_LEN)
      begin
        if (RX_DATA != s_r.station[8*cur_pos[2:0] +: 8])
          s_nxt.own_ok = 1'b0;
        if (RX_DATA != SYNC_BYTE)
          s_nxt.bc_ok = 1'b0;
        if (cur_pos == 11'd0)
          s_nxt.mc = RX_DATA[0];
      end

      // masked bytes into each filter crc, in arrival order
      for (int i = 0; i < NUM_FILTERS; i++)
      begin
        f_ofs = tbl.table_q[IDX_OFFSET][8*i +: 8];
        rel   = cur_pos - {3'b000, f_ofs};
        if ((cur_pos >= {3'b000, f_ofs}) && (rel < 11'(MASK_BITS))
            && tbl.table_q[i][rel[4:0]])
          s_nxt.crc[i] = wfd_crc16(s_nxt.crc[i], RX_DATA);
      end

      // remote-wake scan past the address fields
      dest_ok = s_nxt.own_ok || s_nxt.bc_ok || s_nxt.mc;
      exp_byte = s_r.station[8*s_r.byte_idx +: 8];
      if (remote_active && dest_ok && (cur_pos >= ADDR_FIELDS_END))
      begin
        case (s_r.scan)
          SCAN_SYNC:
          begin
            if ((s_nxt.ff_cnt == SYNC_LEN)
                && (RX_DATA == s_r.station[7:0]))
            begin
              s_nxt.scan     = SCAN_ADDR;
              s_nxt.byte_idx = 3'd1;
              s_nxt.rep_cnt  = '0;
            end
            else if (RX_DATA == SYNC_BYTE)
              s_nxt.ff_cnt = (s_nxt.ff_cnt == SYNC_LEN) ? SYNC_LEN
                             : s_nxt.ff_cnt + 3'd1;
            else
              s_nxt.ff_cnt = '0;
          end
          SCAN_ADDR:
          begin
            if (RX_DATA == exp_byte)
            begin
              if (s_r.byte_idx == ADDR_LAST_BYTE)
              begin
                s_nxt.byte_idx = '0;
                s_nxt.rep_cnt  = s_r.rep_cnt + 4'd1;
                if (s_r.rep_cnt == ADDR_LAST_REP)
                begin
                  remote_hit   = 1'b1;
                  s_nxt.scan   = SCAN_SYNC;
                  s_nxt.ff_cnt = '0;
                end
              end
              else
                s_nxt.byte_idx = s_r.byte_idx + 3'd1;
            end
            else
            begin
              s_nxt.scan     = SCAN_SYNC;
              s_nxt.rep_cnt  = '0;
              s_nxt.byte_idx = '0;
              s_nxt.ff_cnt   = (RX_DATA == SYNC_BYTE) ? 3'd1 : 3'd0;
            end
          end
          default: s_nxt.scan = SCAN_SYNC;
        endcase
      end
    end

    // sticky status, a hit wins over a same-cycle clear
    if (remote_hit)
      s_nxt.remote_wake_seen_flag = 1'b1;
    if (pattern_hit)
      s_nxt.pattern_wake_seen_flag = 1'b1;

    // reception gate and host notification
    s_nxt.rx_pass = !(s_nxt.remote_wake_scan_enable
                      || s_nxt.pattern_wake_enable || LIGHT_SLEEP);
    s_nxt.irq     = (s_nxt.remote_wake_seen_flag
                     || s_nxt.pattern_wake_seen_flag)
                    && !s_nxt.notify_evt;
    s_nxt.pwr_evt = (s_nxt.remote_wake_seen_flag
                     || s_nxt.pattern_wake_seen_flag)
                    && s_nxt.notify_evt;
  end

  // state register
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s_r         <= '0;
      s_r.station <= STATION_RST;
      s_r.rx_pass <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // every output straight from the state register
  assign AWREADY         = s_r.awready;
  assign WREADY          = s_r.wready;
  assign BVALID          = s_r.bvalid;
  assign BRESP           = s_r.bresp;
  assign ARREADY         = s_r.arready;
  assign RVALID          = s_r.rvalid;
  assign RDATA           = s_r.rdata;
  assign RRESP           = s_r.rresp;
  assign RX_PASS         = s_r.rx_pass;
  assign IRQ_OUT         = s_r.irq;
  assign POWER_EVENT_OUT = s_r.pwr_evt;
endmodule

// ---- testbench/wfd_top_assertions.sv ----
// port-level checker of the wake frame detector, bound to its top module
`timescale 1ns/1ps
module wfd_top_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID,
  input wire logic RX_VALID,
  input wire logic LIGHT_SLEEP,
  input wire logic RX_PASS,
  input wire logic IRQ_OUT,
  input wire logic POWER_EVENT_OUT
);
  // one clock domain, all checks off in reset
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (RST);

  // bus answer timing and refusal while busy
  AST_WR_ANSWER: assert property (AWVALID && AWREADY && WVALID && WREADY
    |=> !BVALID ##1 BVALID) else $error("write response timing wrong");
  AST_RD_ANSWER: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  AST_WR_REFUSE: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  AST_RD_REFUSE: assert property (RVALID |-> !ARREADY)
    else $error("read taken while data pending");

  // notification outputs: one at a time, raised by traffic, held
  AST_NOTIFY_ONE: assert property (!(IRQ_OUT && POWER_EVENT_OUT))
    else $error("both notify outputs high");
  AST_NOTIFY_CAUSE:
    assert property ($rose(IRQ_OUT || POWER_EVENT_OUT) |-> $past(RX_VALID)
      || $past(RX_VALID, 2) || $past(RX_VALID, 3))
    else $error("notify raised without received byte");
  AST_NOTIFY_HOLD:
    assert property ($fell(IRQ_OUT || POWER_EVENT_OUT) |-> BVALID
      || $past(BVALID) || $past(BVALID, 2))
    else $error("notify dropped without host write");

  // normal reception gate follows enables and sleep
  AST_PASS_OFF:
    assert property ($fell(RX_PASS) |-> BVALID || $past(BVALID)
      || LIGHT_SLEEP) else $error("reception blocked without cause");
  AST_PASS_ON:
    assert property ($rose(RX_PASS) |-> BVALID || $past(BVALID)
      || $past(LIGHT_SLEEP) || $past(LIGHT_SLEEP, 2))
    else $error("reception resumed without cause");
  AST_SLEEP_SCAN: assert property (LIGHT_SLEEP [*3] |-> !RX_PASS)
    else $error("reception open in light sleep");
endmodule

bind wfd_top wfd_top_assertions u_chk (
  .CLK(CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY),
  .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RVALID(RVALID), .RX_VALID(RX_VALID),
  .LIGHT_SLEEP(LIGHT_SLEEP), .RX_PASS(RX_PASS), .IRQ_OUT(IRQ_OUT),
  .POWER_EVENT_OUT(POWER_EVENT_OUT)
);

// ---- testbench/wfd_rx_model.sv ----
// receive datapath model that hands frames to the detector
`timescale 1ns/1ps
module wfd_rx_model (
  input  wire logic       clk,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_sof,
  output logic            rx_eof
);
  bit slow;
  // idle at time zero
  initial
  begin
    rx_data  = 8'h00;
    rx_valid = 1'h0;
    rx_sof   = 1'h0;
    rx_eof   = 1'h0;
  end
  // one frame; gaps when slow, idle data never repeats the last byte
  task automatic send(input logic [7:0] f [$]);
    for (int i = 0; i < f.size(); i++)
    begin
      @(posedge clk);
      rx_data  <= f[i];
      rx_valid <= 1'h1;
      rx_sof   <= (i == 0);
      rx_eof   <= (i == f.size() - 1);
      if (slow && i % 2 == 1)
      begin
        @(posedge clk);
        rx_valid <= 1'h0;
        rx_data  <= ~f[i];
      end
    end
    @(posedge clk);
    rx_valid <= 1'h0;
    rx_sof   <= 1'h0;
    rx_eof   <= 1'h0;
    rx_data  <= ~f[f.size() - 1];
  endtask
endmodule

// ---- testbench/wfd_top_test.sv ----
// self-checking bench of the wake frame detector
`timescale 1ns/1ps
module wfd_top_test;
  import wfd_pkg::*;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [3:0]  wstrb = 4'hF;
  logic [31:0] wdata = 32'h0, seed = 32'hFE03F30B;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, light_sleep = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, sel, e;
  logic        rx_valid, rx_sof, rx_eof, rx_pass, irq_out, power_event_out;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] rdata, rd_v;
  logic [31:0] w [8];
  logic [7:0]  rx_data;
  logic [7:0]  fr [$];
  logic [47:0] sta;
  int          bad_count = 0, comparisons = 0;

  always #2.5 clk = ~clk;

  wfd_top u_wfd_top (
    .CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .RX_DATA(rx_data), .RX_VALID(rx_valid), .RX_SOF(rx_sof),
    .RX_EOF(rx_eof), .LIGHT_SLEEP(light_sleep), .RX_PASS(rx_pass),
    .IRQ_OUT(irq_out), .POWER_EVENT_OUT(power_event_out)
  );
  wfd_rx_model u_wfd_rx_model (.clk(clk), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof));

  // xorshift source and a 7-bit byte that is never all-ones
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] fb();
    logic [31:0] v;
    v = rnd();
    return {1'h0, v[6:0]};
  endfunction
  // reference crc-16, msb of each byte first
  function automatic logic [15:0] crc(input logic [15:0] c,
                                      input logic [7:0]  d);
    for (int k = 7; k >= 0; k--)
      c = {c[14:0], 1'h0} ^ ((c[15] ^ d[k]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // compare and count
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one axi4-lite write or read, waiting for the answer under a bound
  task automatic bus(input bit wr, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    bit got;
    n = 0;
    got = 0;
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= wr;
    wvalid <= wr;
    bready <= wr;
    arvalid <= !wr;
    rready <= !wr;
    while (!got && n < 100)
    begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
      got = wr ? bvalid : rvalid;
      rsp = wr ? bresp : rresp;
      rd_v = rdata;
    end
    bready <= 1'h0;
    rready <= 1'h0;
    // let one edge pass so the next call never re-drives in this step
    @(posedge clk);
    if (!got)
    begin
      bad_count++;
      test_done();
    end
  endtask
  // sync stream followed by n station address copies
  task automatic sync_run(input int n);
    repeat (6) fr.push_back(8'hFF);
    repeat (n) for (int k = 0; k < 6; k++) fr.push_back(sta[8*k +: 8]);
  endtask
  // remote-wake frame: a broken run, then a full run unless kind 1
  task automatic remote_frame(input int kind, output logic x);
    logic [47:0] dst;
    dst = sta;
    if (kind == 2) dst[7:0] = 8'h03;
    if (kind == 3) dst = 48'hFFFF_FFFF_FFFF;
    if (kind == 4) dst[7:0] = dst[7:0] ^ 8'h02;
    fr = {};
    for (int k = 0; k < 6; k++) fr.push_back(dst[8*k +: 8]);
    repeat (9) fr.push_back(fb());
    sync_run(5);
    fr.push_back(sta[7:0] ^ 8'h80);
    repeat (3) fr.push_back(fb());
    if (kind != 1) sync_run(16);
    repeat (2) fr.push_back(fb());
    x = (kind != 1) && (kind != 4);
  endtask
  // one filter programmed, one random frame scanned
  task automatic pattern(input int t);
    int f, off;
    logic [31:0] m, b;
    logic [15:0] c;
    f = t % 4;
    m = rnd() | 32'h8000_0000;
    off = 12 + int'(rnd() % 20);
    for (int i = 0; i < 8; i++) w[i] = rnd();
    w[f] = m;
    w[4] = 32'h0;
    w[4][8*f +: 4] = {t % 2 == 1, 2'h0, t != 4};
    w[5][8*f +: 8] = off[7:0];
    b = rnd();
    b[0] = (t % 2 == 1) ^ (t >= 6);
    fr = {b[7:0]};
    for (int i = 1; i < off + 33; i++) fr.push_back(fb());
    c = CRC_INIT;
    for (int j = 0; j < 31; j++) if (m[j]) c = crc(c, fr[off + j]);
    w[6 + f / 2][16 * (f % 2) +: 16] = (t == 5) ? ~c : c;
    bus(1, OFS_CTRL, 32'h0000_000A);
    for (int i = 0; i < 8; i++) bus(1, OFS_TABLE, w[i]);
    bus(0, OFS_TABLE, 32'h0);
    chk("table word", w[0], rd_v);
    chk("rx pass", 0, rx_pass);
    u_wfd_rx_model.slow = (t % 2 == 1);
    u_wfd_rx_model.send(fr);
    repeat (4) @(posedge clk);
    bus(0, OFS_CTRL, 32'h0);
    chk("pattern flag", t < 4, rd_v[BIT_PATTERN_SEEN]);
    chk("irq", t < 4, irq_out);
    bus(1, OFS_CTRL, 32'h0000_0022);
    $display("test pattern %0d done", t);
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    sta = 48'({rnd(), rnd()});
    sta[7:0] = sta[7:0] & 8'h7E;
    chk("rx pass", 1, rx_pass);
    bus(0, OFS_CTRL, 32'h0);
    chk("ctrl reset", 0, rd_v);
    bus(1, 4'h2, 32'h1);
    chk("unmapped wr", RESP_SLVERR, rsp);
    bus(0, 4'h2, 32'h0);
    chk("unmapped rd", RESP_SLVERR, rsp);
    chk("unmapped data", 0, rd_v);
    bus(1, OFS_STA_LO, sta[31:0]);
    bus(1, OFS_STA_HI, {16'h0, sta[47:32]});
    bus(0, OFS_STA_HI, 32'h0);
    chk("station hi", {16'h0, sta[47:32]}, rd_v);
    // only byte lane 1 of an inverted word may land
    wstrb <= 4'h2;
    bus(1, OFS_STA_LO, ~sta[31:0]);
    chk("write resp", RESP_OKAY, rsp);
    wstrb <= 4'hF;
    sta[15:8] = ~sta[15:8];
    bus(0, OFS_STA_LO, 32'h0);
    chk("station lo", sta[31:0], rd_v);
    chk("read resp", RESP_OKAY, rsp);
    $display("test registers done");
    for (int t = 0; t < 8; t++) pattern(t);
    for (int k = 0; k < 5; k++)
    begin
      sel = (k % 2 == 1);
      bus(1, OFS_CTRL, 32'h1 | (sel << 2));
      chk("rx pass", 0, rx_pass);
      remote_frame(k, e);
      u_wfd_rx_model.slow = sel;
      u_wfd_rx_model.send(fr);
      repeat (4) @(posedge clk);
      bus(0, OFS_CTRL, 32'h0);
      chk("remote flag", e, rd_v[BIT_REMOTE_SEEN]);
      chk("irq", e & !sel, irq_out);
      chk("event", e & sel, power_event_out);
      bus(1, OFS_CTRL, 32'h11 | (sel << 2));
      $display("test remote %0d done", k);
    end
    bus(1, OFS_CTRL, 32'h0);
    chk("rx pass", 1, rx_pass);
    for (int s = 0; s < 2; s++)
    begin
      light_sleep <= (s == 1);
      repeat (3) @(posedge clk);
      chk("rx pass", s == 0, rx_pass);
      remote_frame(0, e);
      u_wfd_rx_model.send(fr);
      repeat (4) @(posedge clk);
      bus(0, OFS_CTRL, 32'h0);
      chk("sleep flag", s, rd_v[BIT_REMOTE_SEEN]);
      bus(1, OFS_CTRL, 32'h30);
      $display("test sleep %0d done", s);
    end
    test_done();
  end
endmodule
